/* erpm_monitor.sv */
// Error-rate predictive monitor: per-attribute rate classification,
// failure history and a retained predictive-failure sense report.
// Assumes event strobes and configuration are synchronous to clk; the
// sense report survives power loss only if an outside store saves it
// and drives it back through sense_restore after reset.
`include "erpm_consts.svh"

module erpm_monitor
  import erpm_pkg::*;
#(
  parameter int NUM_ATTR = `ERPM_NUM_ATTR,
  parameter int INT_W    = `ERPM_INT_W,
  parameter int ERR_W    = `ERPM_ERR_W,
  parameter int HIST_W   = `ERPM_HIST_W,
  parameter int AW       = (NUM_ATTR > 1) ? $clog2(NUM_ATTR) : 1
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                exception_disable,
  input  wire logic [NUM_ATTR-1:0] op_strobe,
  input  wire logic [NUM_ATTR-1:0] err_strobe,
  input  wire logic [INT_W-1:0]    interval_len [NUM_ATTR],
  input  wire logic [ERR_W-1:0]    err_thresh   [NUM_ATTR],
  input  wire logic [HIST_W-1:0]   pred_thresh  [NUM_ATTR],
  input  wire logic                bus_reset,
  input  wire logic                sense_clear,
  input  wire logic                sense_restore,
  input  wire logic [AW-1:0]       sense_restore_attr,
  output      logic [NUM_ATTR-1:0] pred_fail,
  output      logic [NUM_ATTR-1:0] unacceptable,
  output      logic [NUM_ATTR-1:0] acceptable,
  output      logic [HIST_W-1:0]   history      [NUM_ATTR],
  output      logic                pred_event,
  output      logic                sense_valid,
  output      logic [AW-1:0]       sense_attr,
  output      erpm_sense_t         sense_code
);

  typedef struct packed {
    logic [NUM_ATTR-1:0] pred_d;
    logic                event_p;
    logic                valid;
    logic [AW-1:0]       attr;
    erpm_sense_t         code;
    logic                restored;
  } erpm_top_st_t;

  erpm_top_st_t        st_ff;
  erpm_top_st_t        nxt_st;
  logic [NUM_ATTR-1:0] pred_now;
  logic [NUM_ATTR-1:0] rise;
  logic [AW-1:0]       rise_idx;

  //////////////////////////////////////////////////////////////////////////
  // one private counter set per attribute
  for (genvar i = 0; i < NUM_ATTR; i++) begin : g_attr
    erpm_attr_if #(
      .INT_W  (INT_W),
      .ERR_W  (ERR_W),
      .HIST_W (HIST_W)
    ) ifc ();

    assign ifc.op           = op_strobe[i];
    assign ifc.err          = err_strobe[i];
    assign ifc.halt         = exception_disable;
    assign ifc.interval_len = interval_len[i];
    assign ifc.err_thresh   = err_thresh[i];
    assign ifc.pred_thresh  = pred_thresh[i];
    assign pred_now[i]      = ifc.pred;
    assign unacceptable[i]  = ifc.unacc;
    assign acceptable[i]    = ifc.acc;
    assign history[i]       = ifc.history;

    erpm_attr_ctr #(
      .INT_W  (INT_W),
      .ERR_W  (ERR_W),
      .HIST_W (HIST_W)
    ) u_ctr (
      .clk   (clk),
      .rst_n (rst_n),
      .a     (ifc.ctr)
    );
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    rise = pred_now & ~st_ff.pred_d;
    rise_idx = '0;
    // Lowest-numbered attribute wins when several fail together.
    for (int k = NUM_ATTR - 1; k >= 0; k--) begin
      if (rise[k]) begin
        rise_idx = AW'(k);
      end
    end
    nxt_st.pred_d = pred_now;
    nxt_st.event_p = 1'b0;
    // The saved report is taken once, on the first cycle after reset.
    if (!st_ff.restored) begin
      nxt_st.restored = 1'b1;
      if (sense_restore) begin
        nxt_st.valid = 1'b1;
        nxt_st.attr = sense_restore_attr;
        nxt_st.code = ERPM_SENSE_PRED;
      end
    end else if ((rise != '0) && !exception_disable) begin
      nxt_st.event_p = 1'b1;
      nxt_st.valid = 1'b1;
      nxt_st.attr = rise_idx;
      nxt_st.code = ERPM_SENSE_PRED;
    end else if (sense_clear) begin
      // A bus reset is deliberately ignored here so the report survives.
      nxt_st.valid = 1'b0;
      nxt_st.attr = '0;
      nxt_st.code = `ERPM_RST_SENSE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pred_fail forced low while disabled; pred_event and the sense report are not masked
  assign pred_fail   = exception_disable ? '0 : pred_now;
  assign pred_event  = st_ff.event_p;
  assign sense_valid = st_ff.valid;
  assign sense_attr  = st_ff.attr;
  assign sense_code  = st_ff.code;

  // Bus reset has no effect on the monitor at all.
  logic unused_bus_reset;
  assign unused_bus_reset = bus_reset;

endmodule // erpm_monitor

/* erpm_consts.svh */
// Constants for the error-rate predictive monitor.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ERPM_CONSTS_SVH
`define ERPM_CONSTS_SVH

// Sense report fields for a predictive failure: key, code and qualifier.
`define ERPM_SENSE_KEY   8'h01
`define ERPM_SENSE_ASC   8'h5D
`define ERPM_SENSE_ASCQ  8'h00

// Reset values of the counters and of the sense report.
`define ERPM_RST_COUNT   1'b0
`define ERPM_RST_SENSE   24'h00_0000

// Default widths of the interval, failure and history counters, and the default number of attributes.
`define ERPM_INT_W       16
`define ERPM_ERR_W       8
`define ERPM_HIST_W      8
`define ERPM_NUM_ATTR    4

`endif

/* erpm_pkg.sv */
// Types shared by the error-rate predictive monitor modules.
// Assumes erpm_consts.svh is on the include path.
`include "erpm_consts.svh"

package erpm_pkg;

  typedef struct packed {
    logic [7:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } erpm_sense_t;

  localparam erpm_sense_t ERPM_SENSE_PRED = '{
    key:  `ERPM_SENSE_KEY,
    asc:  `ERPM_SENSE_ASC,
    ascq: `ERPM_SENSE_ASCQ
  };

endpackage

/* erpm_attr_if.sv */
// Carrier between the monitor top and one per-attribute counter block.
// Assumes one instance per attribute, all on the monitor's clock.
`include "erpm_consts.svh"

interface erpm_attr_if #(
  parameter int INT_W  = `ERPM_INT_W,
  parameter int ERR_W  = `ERPM_ERR_W,
  parameter int HIST_W = `ERPM_HIST_W
);
  logic              op;
  logic              err;
  logic              halt;
  logic [INT_W-1:0]  interval_len;
  logic [ERR_W-1:0]  err_thresh;
  logic [HIST_W-1:0] pred_thresh;
  logic              unacc;
  logic              acc;
  logic              pred;
  logic [HIST_W-1:0] history;

  modport ctr (
    input  op, err, halt, interval_len, err_thresh, pred_thresh,
    output unacc, acc, pred, history
  );
  modport mon (
    output op, err, halt, interval_len, err_thresh, pred_thresh,
    input  unacc, acc, pred, history
  );
endinterface

/* erpm_attr_ctr.sv */
// Interval, failure and history counters for one monitored attribute.
// Assumes strobes are one cycle wide and synchronous to clk.
`include "erpm_consts.svh"

module erpm_attr_ctr
  import erpm_pkg::*;
#(
  parameter int INT_W  = `ERPM_INT_W,
  parameter int ERR_W  = `ERPM_ERR_W,
  parameter int HIST_W = `ERPM_HIST_W
) (
  input wire logic clk,
  input wire logic rst_n,
  erpm_attr_if.ctr a
);

  typedef struct packed {
    logic [INT_W-1:0]  ivl;
    logic [ERR_W-1:0]  fail;
    logic [HIST_W-1:0] hist;
    logic              unacc;
    logic              acc;
    logic              pred;
  } erpm_attr_st_t;

  erpm_attr_st_t st_ff;
  erpm_attr_st_t nxt_st;
  logic [INT_W-1:0] ivl_n;
  logic [ERR_W-1:0] fail_n;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.unacc = 1'b0;
    nxt_st.acc = 1'b0;
    ivl_n = st_ff.ivl;
    fail_n = st_ff.fail;
    if (a.halt) begin
      nxt_st.pred = 1'b0;
    end else begin
      if (a.op && (st_ff.ivl != {INT_W{1'b1}})) begin
        ivl_n = st_ff.ivl + INT_W'(1);
      end
      if (a.err && (st_ff.fail != {ERR_W{1'b1}})) begin
        fail_n = st_ff.fail + ERR_W'(1);
      end
      nxt_st.ivl = ivl_n;
      nxt_st.fail = fail_n;
      if (fail_n > a.err_thresh) begin
        nxt_st.unacc = 1'b1;
      end else if (a.op && (ivl_n >= a.interval_len)) begin
        nxt_st.acc = 1'b1;
      end
      if (nxt_st.unacc || nxt_st.acc) begin
        nxt_st.ivl = '0;
        nxt_st.fail = '0;
      end
      if (nxt_st.unacc && (st_ff.hist != {HIST_W{1'b1}})) begin
        nxt_st.hist = st_ff.hist + HIST_W'(1);
      end else if (nxt_st.acc && (st_ff.hist != '0)) begin
        nxt_st.hist = st_ff.hist - HIST_W'(1);
      end
      nxt_st.pred = (nxt_st.hist >= a.pred_thresh);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign a.unacc   = st_ff.unacc;
  assign a.acc     = st_ff.acc;
  assign a.pred    = st_ff.pred;
  assign a.history = st_ff.hist;

endmodule // erpm_attr_ctr

/* erpm_monitor_props.sv */
// Port assertions for attribute 0, the disable masking of every attribute, and the sense report.
// Assumes one clock domain with synchronous active-low reset.
module erpm_monitor_props
  import erpm_pkg::*;
#(
  parameter int NUM_ATTR = 4,
  parameter int HIST_W   = 8
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                exception_disable,
  input wire logic [NUM_ATTR-1:0] op_strobe,
  input wire logic [NUM_ATTR-1:0] err_strobe,
  input wire logic [HIST_W-1:0]   pred_thresh [NUM_ATTR],
  input wire logic                sense_clear,
  input wire logic [NUM_ATTR-1:0] pred_fail,
  input wire logic [NUM_ATTR-1:0] unacceptable,
  input wire logic [NUM_ATTR-1:0] acceptable,
  input wire logic [HIST_W-1:0]   history [NUM_ATTR],
  input wire logic                pred_event,
  input wire logic                sense_valid,
  input wire erpm_sense_t         sense_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_up;
    unacceptable[0] && $past(history[0]) != 8'hff
      |-> history[0] == $past(history[0]) + 1'b1;
  endproperty
  a_up: assert property (p_up) else $error("history missed a rise");
  property p_dn;
    acceptable[0] |-> history[0] ==
      ($past(history[0]) == 0 ? 0 : $past(history[0]) - 1'b1);
  endproperty
  a_dn: assert property (p_dn) else $error("history missed a fall");
  property p_ucause;
    unacceptable[0] |-> $past(err_strobe[0]);
  endproperty
  a_ucause: assert property (p_ucause) else $error("bad unacc");
  property p_acause;
    acceptable[0] |-> $past(op_strobe[0]) && !unacceptable[0];
  endproperty
  a_acause: assert property (p_acause) else $error("bad acc");
  property p_freeze;
    $past(exception_disable) |-> !unacceptable && !acceptable;
  endproperty
  a_freeze: assert property (p_freeze) else $error("counted while off");
  property p_mask;
    exception_disable |-> pred_fail == '0;
  endproperty
  a_mask: assert property (p_mask) else $error("failure while off");
  property p_pred;
    pred_fail[0] |-> history[0] >= pred_thresh[0];
  endproperty
  a_pred: assert property (p_pred) else $error("early failure");
  property p_post;
    pred_event |-> sense_valid && sense_code == ERPM_SENSE_PRED;
  endproperty
  a_post: assert property (p_post) else $error("bad report");
  property p_keep;
    $past(sense_valid) && !$past(sense_clear) |-> sense_valid;
  endproperty
  a_keep: assert property (p_keep) else $error("report lost");
  c_unacc: cover property (unacceptable[0]);
  c_acc: cover property (acceptable[0]);
  c_event: cover property (pred_event);
endmodule // erpm_monitor_props

bind erpm_monitor erpm_monitor_props #(.NUM_ATTR(NUM_ATTR), .HIST_W(HIST_W))
  u_props (.clk, .rst_n, .exception_disable, .op_strobe, .err_strobe,
    .pred_thresh, .sense_clear, .pred_fail, .unacceptable, .acceptable,
    .history, .pred_event, .sense_valid, .sense_code);

/* erpm_src_model.sv */
// Random operation and error strobes, one pair for each attribute.
// Assumes the monitor clock; err_lvl sets error density in sixteenths.
module erpm_src_model #(
  parameter int N = 4
) (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [3:0] err_lvl,
  output logic [N-1:0]    op_strobe = '0,
  output logic [N-1:0]    err_strobe = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobes move only after the edge, so the monitor samples them settled.
  always @(posedge clk) begin
    #2;
    for (int i = 0; i < N; i++) begin
      op_strobe[i]  <= run && ($urandom % 2 == 1);
      err_strobe[i] <= run && ($urandom % 16 < err_lvl);
    end
  end
endmodule // erpm_src_model

/* erpm_monitor_tb.sv */
// Self-checking bench: random strobes against a counting model.
// Assumes the monitor with default widths and four attributes.
module erpm_monitor_tb;
  import erpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 4;
  logic clk = 0, rst_n = 0, exception_disable = 0, run = 0;
  logic bus_reset = 0, sense_clear = 0, sense_restore = 0;
  logic [1:0]   restore_attr = 2'h0;
  logic [3:0]   err_lvl = 0;
  logic [N-1:0] op_strobe, err_strobe, pred_fail, unacceptable, acceptable;
  logic [15:0]  interval_len [N];
  logic [7:0]   err_thresh [N];
  logic [7:0]   pred_thresh [N];
  logic [7:0]   history [N];
  logic         pred_event, sense_valid;
  logic [1:0]   sense_attr;
  erpm_sense_t  sense_code;
  int failures = 0, check_count = 0;
  int ivl [N], fl [N], hs [N];
  bit eu [N], ea [N];
  bit pf [N], pp [N];
  bit ev, rsd;
  int sv = 0, sa = 0, rz = 0;

  always #25 clk = ~clk;

  erpm_src_model #(.N(N)) src (.clk, .run, .err_lvl, .op_strobe,
    .err_strobe);
  erpm_monitor dut (.clk, .rst_n, .exception_disable, .op_strobe,
    .err_strobe, .interval_len, .err_thresh, .pred_thresh, .bus_reset,
    .sense_clear, .sense_restore, .sense_restore_attr(restore_attr),
    .pred_fail, .unacceptable, .acceptable, .history, .pred_event,
    .sense_valid, .sense_attr, .sense_code);

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Each attribute keeps its own counts; the error decides first.
  always @(posedge clk) begin
    // The report follows last cycle's flags, so it is worked out first.
    rz = -1;
    for (int i = N - 1; i >= 0; i--) begin
      if (pf[i] && !pp[i])
        rz = i;
    end
    ev = 0;
    if (!rst_n) begin
      sv = 0;
      sa = 0;
      rsd = 0;
    end else if (!rsd) begin
      rsd = 1;
      if (sense_restore) begin
        sv = 1;
        sa = restore_attr;
      end
    end else if (rz >= 0 && !exception_disable) begin
      ev = 1;
      sv = 1;
      sa = rz;
    end else if (sense_clear) begin
      sv = 0;
      sa = 0;
    end
    for (int i = 0; i < N; i++) begin
      eu[i] = 0;
      ea[i] = 0;
      pp[i] = pf[i];
      pf[i] = 0;
      if (!rst_n) begin
        ivl[i] = 0;
        fl[i] = 0;
        hs[i] = 0;
        pp[i] = 0;
      end else if (!exception_disable) begin
        fl[i] += err_strobe[i];
        ivl[i] += op_strobe[i];
        eu[i] = fl[i] > err_thresh[i];
        ea[i] = !eu[i] && op_strobe[i] && ivl[i] >= interval_len[i];
        hs[i] += (eu[i] && hs[i] < 255) - (ea[i] && hs[i] > 0);
        if (eu[i] || ea[i]) begin
          ivl[i] = 0;
          fl[i] = 0;
        end
        pf[i] = hs[i] >= pred_thresh[i];
      end
    end
    #1;
    if (rst_n) begin
      chk_bit(pred_event, ev);
      chk_bit(sense_valid, sv);
      chk_word(sense_attr, sa);
      chk_word(sense_code, sv ? 24'(ERPM_SENSE_PRED) : 24'h00_0000);
    end
    for (int i = 0; i < N; i++) begin
      if (rst_n) begin
        chk_bit(unacceptable[i], eu[i]);
        chk_bit(acceptable[i], ea[i]);
        chk_word(history[i], hs[i]);
        chk_bit(pred_fail[i], pf[i]);
      end
    end
  end

  initial begin
    void'($urandom(32'hc089));
    for (int i = 0; i < N; i++) begin
      interval_len[i] = 16'(i * 5 + 1);
      err_thresh[i] = 8'(i);
      pred_thresh[i] = 8'(i + 1);
    end
    repeat (16) @(posedge clk);
    #2 rst_n = 1;
    run = 1;
    err_lvl = 4'h8;
    repeat (1500) @(posedge clk);
    #2 run = 0;
    repeat (3) @(posedge clk);
    #1 chk_word(sense_code, ERPM_SENSE_PRED);
    #1 bus_reset = 1;
    @(posedge clk);
    #2 bus_reset = 0;
    exception_disable = 1;
    repeat (2) @(posedge clk);
    #1 chk_bit(sense_valid, 1'b1);
    #1 sense_clear = 1;
    @(posedge clk);
    #2 sense_clear = 0;
    @(posedge clk);
    #1 chk_bit(sense_valid, 1'b0);
    #1 run = 1;
    err_lvl = 4'h1;
    repeat (2500) begin
      @(posedge clk);
      #2 exception_disable = $urandom % 8 == 0;
    end
    // A second reset with a saved report offered back, as after power loss.
    rst_n = 0;
    exception_disable = 0;
    sense_restore = 1;
    restore_attr = 2'($urandom);
    repeat (2) @(posedge clk);
    #2 rst_n = 1;
    @(posedge clk);
    #1 chk_word(sense_attr, restore_attr);
    #1 sense_restore = 0;
    repeat (4) @(posedge clk);
    end_sim;
  end

  initial begin
    #(8000 * 50);
    failures++;
    end_sim;
  end
endmodule // erpm_monitor_tb
